// ---- testbench/phy_mode_config_sequencer_tb.sv ----
// Self-checking bench for both sequencer ends joined on one bus
`timescale 1ns/1ps
`default_nettype none
module phy_mode_config_sequencer_tb
	import pmcs_pkg::*;
;
	typedef struct packed {
		logic [1:0]  k;
		logic [4:0]  r;
		logic [15:0] w;
		logic [15:0] rd;
		logic        sg;
		logic        an;
		logic [15:0] ab;
	} pmcs_row_t;
	logic        CLK       = 1'b0;
	logic        RESET     = 1'b1;
	logic        CMD_VALID = 1'b0;
	logic [1:0]  CMD_KIND  = 2'h0;
	logic [4:0]  CMD_REG   = 5'h00;
	logic [15:0] CMD_WDATA = 16'h0000;
	logic        RX_ERROR  = 1'b0;
	logic        LINK_UP   = 1'b1;
	logic        CMD_READY, RSP_VALID, RSP_ERROR, HOST_SGMII, AUTONEG_ON;
	logic [15:0] RSP_RDATA, ADV_GIGABIT, ADV_BASIC;
	int          n_fail    = 0;
	int          compares  = 0;
	pmcs_row_t   rows [15] = '{
		'{PMCS_CMD_READ,   5'h1B, 16'h0000, 16'h908F, 1'b0, 1'b1, 16'h01E1},
		'{PMCS_CMD_WRITE,  5'h1B, 16'h9084, 16'h9084, 1'b0, 1'b1, 16'h01E1},
		'{PMCS_CMD_WRITE,  5'h04, 16'h0DE1, 16'h0DE1, 1'b0, 1'b1, 16'h01E1},
		'{PMCS_CMD_WRITE,  5'h00, 16'h9140, 16'h9140, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_READ,   5'h00, 16'h0000, 16'h1140, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_WRITE,  5'h16, 16'h0001, 16'h0001, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_WRITE,  5'h04, 16'h1234, 16'h1234, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_READ,   5'h04, 16'h0000, 16'h1234, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_WRITE,  5'h16, 16'h0000, 16'h0000, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_READ,   5'h04, 16'h0000, 16'h0DE1, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_WRITE,  5'h01, 16'hFFFF, 16'hFFFF, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_READ,   5'h01, 16'h0000, 16'h794D, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_READ,   5'h0B, 16'h0000, 16'h0000, 1'b1, 1'b1, 16'h0DE1},
		'{PMCS_CMD_AN_OFF, 5'h00, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0DE1},
		'{PMCS_CMD_READ,   5'h16, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0DE1}
	};

	pmcs_bus_if bus ();
	pmcs_host #(.QUARTER(4)) pmcs_host_inst (.CLK(CLK), .RESET(RESET),
		.BUS(bus), .CMD_VALID(CMD_VALID), .CMD_KIND(CMD_KIND),
		.CMD_REG(CMD_REG), .CMD_WDATA(CMD_WDATA), .CMD_READY(CMD_READY),
		.RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .RSP_ERROR(RSP_ERROR));
	pmcs_device pmcs_device_inst (.CLK(CLK), .RESET(RESET), .BUS(bus),
		.RX_ERROR(RX_ERROR), .LINK_UP(LINK_UP), .HOST_SGMII(HOST_SGMII),
		.AUTONEG_ON(AUTONEG_ON), .ADV_GIGABIT(ADV_GIGABIT),
		.ADV_BASIC(ADV_BASIC));
	pmcs_bus_asserts #(.QUARTER(4)) pmcs_bus_asserts_inst (.CLK(CLK),
		.RESET(RESET), .scl_o(bus.scl_o), .scl_oe(bus.scl_oe),
		.sda_h_o(bus.sda_h_o), .sda_h_oe(bus.sda_h_oe),
		.sda_d_o(bus.sda_d_o), .sda_d_oe(bus.sda_d_oe),
		.scl(bus.scl), .sda(bus.sda));

	always #5 CLK = ~CLK;

	// =========================================================
	// Shared tasks
	task automatic check(input string nm, input logic [15:0] seen,
			input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Held over one rising edge; the host is idle, so that edge takes it
	task automatic do_cmd(input logic [1:0] k, input logic [4:0] r,
			input logic [15:0] w);
		int i;
		@(negedge CLK);
		CMD_VALID = 1'b1;
		CMD_KIND  = k;
		CMD_REG   = r;
		CMD_WDATA = w;
		@(negedge CLK);
		CMD_VALID = 1'b0;
		for (i = 0; i < 4000 && RSP_VALID !== 1'b1; i++) @(negedge CLK);
		check("response", {15'h0000, RSP_VALID}, 16'h0001);
		check("error", {15'h0000, RSP_ERROR}, 16'h0000);
	endtask

	// =========================================================
	// Sequence
	initial begin
		#500000;
		n_fail++;
		stop_test();
	end

	initial begin
		repeat (8) @(negedge CLK);
		RESET = 1'b0;
		foreach (rows[i]) begin
			do_cmd(rows[i].k, rows[i].r, rows[i].w);
			check("rdata", RSP_RDATA, rows[i].rd);
			check("sgmii", {15'h0000, HOST_SGMII}, 16'(rows[i].sg));
			check("autoneg", {15'h0000, AUTONEG_ON}, 16'(rows[i].an));
			check("adv_basic", ADV_BASIC, rows[i].ab);
		end
		repeat (3) begin
			@(negedge CLK);
			RX_ERROR = 1'b1;
			@(negedge CLK);
			RX_ERROR = 1'b0;
		end
		do_cmd(PMCS_CMD_READ, 5'h15, 16'h0000);
		check("rx_errors", RSP_RDATA, 16'h0003);
		do_cmd(PMCS_CMD_READ, 5'h15, 16'h0000);
		check("rx_cleared", RSP_RDATA, 16'h0000);
		LINK_UP = 1'b0;
		do_cmd(PMCS_CMD_READ, 5'h01, 16'h0000);
		check("link_down", RSP_RDATA, 16'h7949);
		// Mid-run reset must bring back the power-up modes
		@(negedge CLK);
		RESET = 1'b1;
		repeat (2) @(negedge CLK);
		RESET = 1'b0;
		check("rst_sgmii", {15'h0000, HOST_SGMII}, 16'h0000);
		check("rst_autoneg", {15'h0000, AUTONEG_ON}, 16'h0001);
		check("rst_adv_gig", ADV_GIGABIT, 16'h0300);
		check("rst_ready", {15'h0000, CMD_READY}, 16'h0001);
		do_cmd(PMCS_CMD_SGMII, 5'h00, 16'h0000);
		check("seq_sgmii", {15'h0000, HOST_SGMII}, 16'h0001);
		check("seq_adv_gig", ADV_GIGABIT, 16'h0F00);
		check("seq_adv_basic", ADV_BASIC, 16'h0DE1);
		check("seq_last", RSP_RDATA, 16'h9140);
		stop_test();
	end
endmodule // phy_mode_config_sequencer_tb
`default_nettype wire

// ---- testbench/pmcs_bus_asserts.sv ----
// Checker for the two-wire bus between the sequencer ends
`timescale 1ns/1ps
`default_nettype none
module pmcs_bus_asserts #(
	parameter int QUARTER = 4
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_h_o,
	input wire logic sda_h_oe,
	input wire logic sda_d_o,
	input wire logic sda_d_oe,
	input wire logic scl,
	input wire logic sda
);
	// =========================================================
	// Bus decoding helpers
	// Longest frame is a read with repeated start, about 190 quarters
	localparam int FRAME_MAX = 200 * QUARTER;
	logic       scl_q;
	logic       sda_q;
	logic [7:0] high_cnt;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic       first;
	wire        start_w = scl & scl_q & sda_q & ~sda;
	wire        rise_w  = scl & ~scl_q;

	always_ff @(posedge CLK) begin
		scl_q <= scl;
		sda_q <= sda;
	end

	// Saturates high so the idle time before a start never counts short
	always_ff @(posedge CLK) begin
		if (RESET) high_cnt <= 8'hFF;
		else if (!scl) high_cnt <= 8'h00;
		else if (high_cnt != 8'hFF) high_cnt <= high_cnt + 8'h01;
	end

	always_ff @(posedge CLK) begin
		if (RESET || start_w) begin
			bit_cnt <= 4'h0;
			first   <= 1'b1;
		end else if (rise_w) begin
			shift   <= {shift[6:0], sda};
			bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
			if (bit_cnt == 4'h8) first <= 1'b0;
		end
	end

	// =========================================================
	// Properties
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	sequence s_ack9;
		$rose(scl) && bit_cnt == 4'h8 && first;
	endsequence

	chk_drive_low_only: assert property (!scl_o && !sda_h_o && !sda_d_o)
		else $error("open-drain output driven high");
	chk_start_by_host: assert property (s_start |-> sda_h_oe)
		else $error("start not made by host");
	chk_stop_frees: assert property (s_stop |-> !sda_h_oe && !sda_d_oe)
		else $error("bus held after stop");
	chk_scl_high_len: assert property ($fell(scl) |-> high_cnt >= 2 * QUARTER)
		else $error("clock high phase too short");
	chk_dev_sda_edge: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl))
		else $error("device data moved while clock high");
	chk_addr_byte: assert property (s_ack9 |-> shift[7:1] == 7'h56)
		else $error("wrong device address on bus");
	chk_addr_ack: assert property (s_ack9 |-> !sda && sda_d_oe)
		else $error("device address not acknowledged");
	chk_host_frees_ack: assert property (s_ack9 |-> !sda_h_oe)
		else $error("host drove data in acknowledge slot");
	chk_frame_ends: assert property (s_start |-> ##[1:FRAME_MAX] s_stop)
		else $error("transaction not closed by stop");
endmodule // pmcs_bus_asserts
`default_nettype wire

// ---- verilog/pmcs_bus_if.sv ----
// Two-wire bus between the host sequencer and the device end
`timescale 1ns/1ps
`default_nettype none
interface pmcs_bus_if;
	logic scl_o;
	logic scl_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	// Open-drain wires with pull-ups: low while any enabled driver is low
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

	modport host   (output scl_o, scl_oe, sda_h_o, sda_h_oe,
	                input  scl, sda);
	modport device (output sda_d_o, sda_d_oe, input scl, sda);
endinterface
`default_nettype wire

// ---- verilog/pmcs_device.sv ----
// Device end: two-wire slave, paged register file and mode state
`timescale 1ns/1ps
`default_nettype none
module pmcs_device
	import pmcs_pkg::*;
#(
	parameter logic [15:0] ID_HIGH = 16'h0A5A, // Arbitrary identity value
	parameter logic [15:0] ID_LOW  = 16'h5A00  // Arbitrary identity value
) (
	input  wire logic        CLK,
	input  wire logic        RESET,
	pmcs_bus_if.device       BUS,
	input  wire logic        RX_ERROR,
	input  wire logic        LINK_UP,
	output var  logic        HOST_SGMII,
	output var  logic        AUTONEG_ON,
	output var  logic [15:0] ADV_GIGABIT,
	output var  logic [15:0] ADV_BASIC
);

	// =====================================================================
	// Address classes
	function automatic logic is_paged(input logic [4:0] a);
		return (a <= PMCS_REG_PARTNER_NEXT && a != PMCS_REG_IDENTIFIER_HIGH &&
		        a != PMCS_REG_IDENTIFIER_LOW) ||
		       (a >= PMCS_REG_SPECIFIC_STATUS && a <= PMCS_REG_IRQ_STATUS);
	endfunction

	function automatic logic is_writable(input logic [4:0] a);
		unique case (a)
			PMCS_REG_BASIC_CONTROL, PMCS_REG_NEG_ADVERTISE,
			PMCS_REG_NEXT_PAGE_OUT, PMCS_REG_GIGABIT_CONTROL,
			PMCS_REG_SPECIFIC_CTRL, PMCS_REG_IRQ_ENABLE,
			PMCS_REG_EXT_SPEC_CTRL, PMCS_REG_PAGE_SELECT,
			PMCS_REG_INDICATOR_CTRL, PMCS_REG_INDICATOR_OVR,
			PMCS_REG_EXT_SPEC_CTRL2, PMCS_REG_EXT_SPEC_MODE: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic is_mapped(input logic [4:0] a);
		return a <= PMCS_REG_EXT_SPEC_MODE &&
		       !(a > PMCS_REG_GIGABIT_STATUS && a < PMCS_REG_EXTENDED_STATUS);
	endfunction

	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_RECV = 3'b001,
		D_ACK  = 3'b010,
		D_SEND = 3'b011,
		D_RACK = 3'b100
	} pmcs_dstate_t;

	pmcs_dstate_t state_reg;
	logic         scl_q;
	logic         sda_q;
	logic [3:0]   cnt_reg;
	logic [2:0]   idx_reg;
	logic [7:0]   sh_reg;
	logic [4:0]   ptr_reg;
	logic [7:0]   hi_reg;
	logic         rd_mode_reg;
	logic [15:0]  tx_reg;
	logic         lo_pend_reg;
	logic         acked_reg;
	logic         sda_drv_reg;
	logic         wr_fire_reg;
	logic [15:0]  wr_data_reg;
	logic         rd_fire_reg;
	logic [15:0]  pg_mem [0:1][0:31];
	logic [15:0]  sh_mem [0:31];
	logic [15:0]  rx_cnt_reg;
	logic [15:0]  rd_word;

	// =====================================================================
	// Bus condition detection
	wire scl_rise = BUS.scl & ~scl_q;
	wire scl_fall = ~BUS.scl & scl_q;
	wire start_c  = BUS.scl & scl_q & sda_q & ~BUS.sda;
	wire stop_c   = BUS.scl & scl_q & ~sda_q & BUS.sda;
	wire addr_hit = sh_reg[7:1] == PMCS_DEV_ADDR[7:1];
	wire take_byte = (idx_reg == 3'd0) ? addr_hit :
	                 (idx_reg <= 3'd3 && !rd_mode_reg);
	wire bank      = sh_mem[PMCS_REG_PAGE_SELECT][0];
	wire paged     = is_paged(ptr_reg);
	wire wr_ok     = wr_fire_reg && is_writable(ptr_reg);
	wire is_ctrl   = ptr_reg == PMCS_REG_BASIC_CONTROL;
	wire soft_rst  = wr_fire_reg && is_ctrl &&
	                 wr_data_reg[PMCS_CTRL_RESET_BIT];
	wire an_cop    = (is_ctrl && !bank) ? wr_data_reg[PMCS_CTRL_AN_BIT] :
	                 pg_mem[0][PMCS_REG_BASIC_CONTROL][PMCS_CTRL_AN_BIT];
	wire an_fib    = (is_ctrl && bank) ? wr_data_reg[PMCS_CTRL_AN_BIT] :
	                 pg_mem[1][PMCS_REG_BASIC_CONTROL][PMCS_CTRL_AN_BIT];
	wire [15:0] store_data = is_ctrl ?
		(wr_data_reg & ~(16'h0001 << PMCS_CTRL_RESET_BIT)) : wr_data_reg;
	wire rx_read   = rd_fire_reg && ptr_reg == PMCS_REG_RX_ERROR_COUNT;

	assign BUS.sda_d_o  = 1'b0;
	assign BUS.sda_d_oe = sda_drv_reg;

	// =====================================================================
	// Read selection
	always_comb begin
		rd_word = 16'h0000;
		unique case (ptr_reg)
			PMCS_REG_BASIC_STATUS: begin
				rd_word = PMCS_STATUS_BASE;
				rd_word[PMCS_STATUS_LINK_BIT] = LINK_UP;
			end
			PMCS_REG_IDENTIFIER_HIGH: rd_word = ID_HIGH;
			PMCS_REG_IDENTIFIER_LOW:  rd_word = ID_LOW;
			PMCS_REG_RX_ERROR_COUNT:  rd_word = rx_cnt_reg;
			default: begin
				if (paged) begin
					rd_word = pg_mem[bank][ptr_reg];
				end else if (is_mapped(ptr_reg)) begin
					rd_word = sh_mem[ptr_reg];
				end
			end
		endcase
	end

	// =====================================================================
	// Slave byte engine
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_reg   <= D_IDLE;
			scl_q       <= 1'b1;
			sda_q       <= 1'b1;
			cnt_reg     <= 4'h0;
			idx_reg     <= 3'h0;
			sh_reg      <= 8'h00;
			ptr_reg     <= 5'h00;
			hi_reg      <= 8'h00;
			rd_mode_reg <= 1'b0;
			tx_reg      <= 16'h0000;
			lo_pend_reg <= 1'b0;
			acked_reg   <= 1'b0;
			sda_drv_reg <= 1'b0;
			wr_fire_reg <= 1'b0;
			wr_data_reg <= 16'h0000;
			rd_fire_reg <= 1'b0;
		end else begin
			scl_q       <= BUS.scl;
			sda_q       <= BUS.sda;
			wr_fire_reg <= 1'b0;
			rd_fire_reg <= 1'b0;
			if (start_c) begin
				state_reg   <= D_RECV;
				cnt_reg     <= 4'h0;
				idx_reg     <= 3'h0;
				sda_drv_reg <= 1'b0;
			end else if (stop_c) begin
				state_reg   <= D_IDLE;
				sda_drv_reg <= 1'b0;
			end else begin
				unique case (state_reg)
					D_IDLE: begin
					end
					D_RECV: begin
						if (scl_rise) begin
							sh_reg  <= {sh_reg[6:0], BUS.sda};
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall && cnt_reg == 4'h8) begin
							cnt_reg <= 4'h0;
							if (take_byte) begin
								sda_drv_reg <= 1'b1;
								state_reg   <= D_ACK;
								idx_reg     <= idx_reg + 3'h1;
								unique case (idx_reg)
									3'd0: rd_mode_reg <= sh_reg[0];
									3'd1: ptr_reg <= sh_reg[4:0];
									3'd2: hi_reg <= sh_reg;
									default: begin
										wr_fire_reg <= 1'b1;
										wr_data_reg <= {hi_reg, sh_reg};
									end
								endcase
							end else begin
								// Foreign address or surplus byte: no acknowledge
								state_reg <= D_IDLE;
							end
						end
					end
					D_ACK: begin
						if (scl_fall) begin
							if (rd_mode_reg) begin
								tx_reg      <= rd_word;
								rd_fire_reg <= 1'b1;
								sda_drv_reg <= ~rd_word[15];
								cnt_reg     <= 4'h1;
								lo_pend_reg <= 1'b1;
								state_reg   <= D_SEND;
							end else begin
								sda_drv_reg <= 1'b0;
								state_reg   <= D_RECV;
							end
						end
					end
					D_SEND: begin
						if (scl_fall) begin
							if (cnt_reg == 4'h8) begin
								sda_drv_reg <= 1'b0;
								state_reg   <= D_RACK;
							end else begin
								sda_drv_reg <= ~tx_reg[14];
								tx_reg      <= {tx_reg[14:0], 1'b0};
								cnt_reg     <= cnt_reg + 4'h1;
							end
						end
					end
					D_RACK: begin
						if (scl_rise) begin
							acked_reg <= ~BUS.sda;
						end else if (scl_fall) begin
							if (acked_reg && lo_pend_reg) begin
								lo_pend_reg <= 1'b0;
								// Seven shifts so far: low byte's top bit is at 14
								sda_drv_reg <= ~tx_reg[14];
								tx_reg      <= {tx_reg[14:0], 1'b0};
								cnt_reg     <= 4'h1;
								state_reg   <= D_SEND;
							end else begin
								state_reg <= D_IDLE;
							end
						end
					end
					default: state_reg <= D_IDLE;
				endcase
			end
		end
	end

	// =====================================================================
	// Register file and applied settings
	always_ff @(posedge CLK) begin
		if (RESET) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < 32; i++) begin
					pg_mem[b][i] <= 16'h0000;
				end
				pg_mem[b][PMCS_REG_BASIC_CONTROL] <= PMCS_RST_CONTROL;
				pg_mem[b][PMCS_REG_NEG_ADVERTISE] <= PMCS_RST_ADV_BASIC;
			end
			for (int i = 0; i < 32; i++) begin
				sh_mem[i] <= 16'h0000;
			end
			sh_mem[PMCS_REG_EXT_SPEC_MODE]   <= PMCS_RST_MODE;
			sh_mem[PMCS_REG_GIGABIT_CONTROL] <= PMCS_RST_ADV_GIG;
			rx_cnt_reg  <= 16'h0000;
			HOST_SGMII  <= 1'b0;
			AUTONEG_ON  <= 1'b1;
			ADV_GIGABIT <= PMCS_RST_ADV_GIG;
			ADV_BASIC   <= PMCS_RST_ADV_BASIC;
		end else begin
			if (wr_ok) begin
				if (paged) begin
					pg_mem[bank][ptr_reg] <= store_data;
				end else begin
					sh_mem[ptr_reg] <= store_data;
				end
			end
			// Staged values only reach the outputs here
			if (soft_rst) begin
				HOST_SGMII  <= sh_mem[PMCS_REG_EXT_SPEC_MODE][3:0]
				               == PMCS_MODE_SGMII;
				AUTONEG_ON  <= an_cop & an_fib;
				ADV_GIGABIT <= sh_mem[PMCS_REG_GIGABIT_CONTROL];
				ADV_BASIC   <= pg_mem[0][PMCS_REG_NEG_ADVERTISE];
			end
			// Read clears, but an error in the same cycle still counts
			if (rx_read) begin
				rx_cnt_reg <= RX_ERROR ? 16'h0001 : 16'h0000;
			end else if (RX_ERROR && rx_cnt_reg != 16'hFFFF) begin
				rx_cnt_reg <= rx_cnt_reg + 16'h0001;
			end
		end
	end

endmodule // pmcs_device
`default_nettype wire

// ---- verilog/pmcs_host.sv ----
// Host end: two-wire master running single accesses and sequences
//
// How it works
// - Answers only at bus address 0xAC
// - Powers up in 1000 full-duplex serializer mode
// - Mode 0x9084 in register 0x1B selects SGMII
// - Changes apply only on control software reset
// - Host SGMII sequence order, six writes
// - Auto-negotiation enabled until reconfigured
// - Page one control 0x8140 disables negotiation
// - Per-page copper/fiber banks chosen by register 22
// - Receive error counter read at address 21
`timescale 1ns/1ps
`default_nettype none
module pmcs_host
	import pmcs_pkg::*;
#(
	parameter int QUARTER = PMCS_QUARTER_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RESET,
	pmcs_bus_if.host         BUS,
	input  wire logic        CMD_VALID,
	input  wire logic [1:0]  CMD_KIND,
	input  wire logic [4:0]  CMD_REG,
	input  wire logic [15:0] CMD_WDATA,
	output var  logic        CMD_READY,
	output var  logic        RSP_VALID,
	output var  logic [15:0] RSP_RDATA,
	output var  logic        RSP_ERROR
);

	// =====================================================================
	// Sequence table: {register, data}
	function automatic logic [20:0] seq_entry(input logic [3:0] i);
		unique case (i)
			4'h0: return {PMCS_REG_EXT_SPEC_MODE, PMCS_VAL_SGMII_MODE};
			4'h1: return {PMCS_REG_BASIC_CONTROL, PMCS_VAL_SOFT_RESET};
			4'h2: return {PMCS_REG_PAGE_SELECT, PMCS_VAL_PAGE0};
			4'h3: return {PMCS_REG_GIGABIT_CONTROL, PMCS_VAL_ADV_GIG};
			4'h4: return {PMCS_REG_NEG_ADVERTISE, PMCS_VAL_ADV_BASIC};
			4'h5: return {PMCS_REG_BASIC_CONTROL, PMCS_VAL_SOFT_RESET};
			4'h6: return {PMCS_REG_PAGE_SELECT, PMCS_VAL_PAGE1};
			4'h7: return {PMCS_REG_BASIC_CONTROL, PMCS_VAL_AN_OFF};
			default: return {PMCS_REG_PAGE_SELECT, PMCS_VAL_PAGE0};
		endcase
	endfunction

	// Transaction steps; reads use a repeated start
	function automatic pmcs_op_t op_of(input logic rd, input logic [3:0] s);
		unique case (s)
			4'h0: return PMCS_OP_START;
			4'h1, 4'h2: return PMCS_OP_WRITE;
			4'h3: return rd ? PMCS_OP_START : PMCS_OP_WRITE;
			4'h4: return PMCS_OP_WRITE;
			4'h5: return rd ? PMCS_OP_RDACK : PMCS_OP_STOP;
			4'h6: return rd ? PMCS_OP_RDNAK : PMCS_OP_END;
			4'h7: return rd ? PMCS_OP_STOP : PMCS_OP_END;
			default: return PMCS_OP_END;
		endcase
	endfunction

	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_NEXT  = 3'b001,
		H_START = 3'b010,
		H_BYTE  = 3'b011,
		H_STOP  = 3'b100
	} pmcs_hstate_t;

	pmcs_hstate_t state_reg;
	pmcs_op_t     op_reg;
	logic [15:0]  div_reg;
	logic [1:0]   ph_reg;
	logic [3:0]   bit_reg;
	logic [3:0]   step_reg;
	logic [7:0]   sh_reg;
	logic         rd_reg;
	logic         seq_reg;
	logic [3:0]   idx_reg;
	logic [3:0]   last_reg;
	logic [4:0]   addr_reg;
	logic [15:0]  data_reg;
	logic         err_reg;
	logic         scl_reg;
	logic         sda_reg;

	wire       tick    = div_reg == 16'(QUARTER - 1);
	wire       running = state_reg != H_IDLE && state_reg != H_NEXT;
	pmcs_op_t  cur_op;
	assign     cur_op  = op_of(rd_reg, step_reg);
	wire [7:0] cur_byte =
		(step_reg == 4'h1) ? PMCS_DEV_ADDR :
		(step_reg == 4'h2) ? {3'b000, addr_reg} :
		(step_reg == 4'h3) ? data_reg[15:8] :
		rd_reg ? (PMCS_DEV_ADDR | 8'h01) : data_reg[7:0];
	wire [20:0] nxt_entry = seq_entry(idx_reg + 4'h1);
	wire        ack_bit   = bit_reg == 4'h8;

	assign BUS.scl_o   = 1'b0;
	assign BUS.scl_oe  = ~scl_reg;
	assign BUS.sda_h_o = 1'b0;
	assign BUS.sda_h_oe = ~sda_reg;

	always_ff @(posedge CLK) begin
		if (RESET || !running || tick) begin
			div_reg <= 16'h0000;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end

	// =====================================================================
	// Command and bit sequencing
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_reg <= H_IDLE;
			op_reg    <= PMCS_OP_END;
			ph_reg    <= 2'h0;
			bit_reg   <= 4'h0;
			step_reg  <= 4'h0;
			sh_reg    <= 8'h00;
			rd_reg    <= 1'b0;
			seq_reg   <= 1'b0;
			idx_reg   <= 4'h0;
			last_reg  <= 4'h0;
			addr_reg  <= 5'h00;
			data_reg  <= 16'h0000;
			err_reg   <= 1'b0;
			scl_reg   <= 1'b1;
			sda_reg   <= 1'b1;
			CMD_READY <= 1'b1;
			RSP_VALID <= 1'b0;
			RSP_RDATA <= 16'h0000;
			RSP_ERROR <= 1'b0;
		end else begin
			RSP_VALID <= 1'b0;
			unique case (state_reg)
				H_IDLE: begin
					if (CMD_VALID) begin
						CMD_READY <= 1'b0;
						step_reg  <= 4'h0;
						err_reg   <= 1'b0;
						rd_reg    <= CMD_KIND == PMCS_CMD_READ;
						seq_reg   <= CMD_KIND[1];
						state_reg <= H_NEXT;
						if (CMD_KIND == PMCS_CMD_SGMII) begin
							idx_reg  <= PMCS_SEQ_SGMII_FIRST;
							last_reg <= PMCS_SEQ_SGMII_LAST;
							{addr_reg, data_reg} <= seq_entry(PMCS_SEQ_SGMII_FIRST);
						end else if (CMD_KIND == PMCS_CMD_AN_OFF) begin
							idx_reg  <= PMCS_SEQ_AN_FIRST;
							last_reg <= PMCS_SEQ_AN_LAST;
							{addr_reg, data_reg} <= seq_entry(PMCS_SEQ_AN_FIRST);
						end else begin
							addr_reg <= CMD_REG;
							data_reg <= CMD_WDATA;
						end
					end
				end
				H_NEXT: begin
					ph_reg  <= 2'h0;
					bit_reg <= 4'h0;
					op_reg  <= cur_op;
					sh_reg  <= (cur_op == PMCS_OP_WRITE) ? cur_byte : 8'hFF;
					unique case (cur_op)
						PMCS_OP_START: state_reg <= H_START;
						PMCS_OP_STOP:  state_reg <= H_STOP;
						PMCS_OP_END: begin
							// Next write only after a fully acknowledged one
							if (seq_reg && !err_reg && idx_reg != last_reg) begin
								idx_reg  <= idx_reg + 4'h1;
								{addr_reg, data_reg} <= nxt_entry;
								step_reg <= 4'h0;
							end else begin
								state_reg <= H_IDLE;
								CMD_READY <= 1'b1;
								RSP_VALID <= 1'b1;
								RSP_ERROR <= err_reg;
								RSP_RDATA <= data_reg;
							end
						end
						default: state_reg <= H_BYTE;
					endcase
				end
				H_START: begin
					if (tick) begin
						ph_reg <= ph_reg + 2'h1;
						unique case (ph_reg)
							2'h0: begin
								scl_reg <= 1'b0;
								sda_reg <= 1'b1;
							end
							2'h1: scl_reg <= 1'b1;
							2'h2: sda_reg <= 1'b0;
							default: begin
								scl_reg   <= 1'b0;
								step_reg  <= step_reg + 4'h1;
								state_reg <= H_NEXT;
							end
						endcase
					end
				end
				H_BYTE: begin
					if (tick) begin
						ph_reg <= ph_reg + 2'h1;
						unique case (ph_reg)
							2'h0: begin
								scl_reg <= 1'b0;
								sda_reg <= ack_bit ? (op_reg != PMCS_OP_RDACK) :
								           sh_reg[7];
							end
							2'h1: scl_reg <= 1'b1;
							2'h2: begin
								if (!ack_bit && op_reg != PMCS_OP_WRITE) begin
									data_reg <= {data_reg[14:0], BUS.sda};
								end
								if (ack_bit && op_reg == PMCS_OP_WRITE && BUS.sda) begin
									err_reg <= 1'b1;
								end
							end
							default: begin
								scl_reg <= 1'b0;
								sh_reg  <= {sh_reg[6:0], 1'b1};
								bit_reg <= bit_reg + 4'h1;
								if (ack_bit) begin
									state_reg <= H_NEXT;
									// Refused byte: finish with a stop
									step_reg <= err_reg ? (rd_reg ? 4'h7 : 4'h5) :
									            step_reg + 4'h1;
								end
							end
						endcase
					end
				end
				H_STOP: begin
					if (tick) begin
						ph_reg <= ph_reg + 2'h1;
						unique case (ph_reg)
							2'h0: begin
								scl_reg <= 1'b0;
								sda_reg <= 1'b0;
							end
							2'h1: scl_reg <= 1'b1;
							2'h2: sda_reg <= 1'b1;
							default: begin
								step_reg  <= step_reg + 4'h1;
								state_reg <= H_NEXT;
							end
						endcase
					end
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end

endmodule // pmcs_host
`default_nettype wire

// ---- verilog/pmcs_pkg.sv ----
// Shared constants and types for the configuration sequencer and its device
`default_nettype none
package pmcs_pkg;

	// =====================================================================
	// Bus addressing and timing
	localparam logic [7:0] PMCS_DEV_ADDR      = 8'hAC;
	localparam int         PMCS_CLK_PERIOD_NS = 10;
	localparam int         PMCS_SCL_PERIOD_NS = 10000;
	localparam int         PMCS_QUARTER_CYC   =
		PMCS_SCL_PERIOD_NS / (4 * PMCS_CLK_PERIOD_NS);

	// =====================================================================
	// Register offsets
	localparam logic [4:0] PMCS_REG_BASIC_CONTROL   = 5'h00;
	localparam logic [4:0] PMCS_REG_BASIC_STATUS    = 5'h01;
	localparam logic [4:0] PMCS_REG_IDENTIFIER_HIGH = 5'h02;
	localparam logic [4:0] PMCS_REG_IDENTIFIER_LOW  = 5'h03;
	localparam logic [4:0] PMCS_REG_NEG_ADVERTISE   = 5'h04;
	localparam logic [4:0] PMCS_REG_PARTNER_ABILITY = 5'h05;
	localparam logic [4:0] PMCS_REG_NEG_EXPANSION   = 5'h06;
	localparam logic [4:0] PMCS_REG_NEXT_PAGE_OUT   = 5'h07;
	localparam logic [4:0] PMCS_REG_PARTNER_NEXT    = 5'h08;
	localparam logic [4:0] PMCS_REG_GIGABIT_CONTROL = 5'h09;
	localparam logic [4:0] PMCS_REG_GIGABIT_STATUS  = 5'h0A;
	localparam logic [4:0] PMCS_REG_EXTENDED_STATUS = 5'h0F;
	localparam logic [4:0] PMCS_REG_SPECIFIC_CTRL   = 5'h10;
	localparam logic [4:0] PMCS_REG_SPECIFIC_STATUS = 5'h11;
	localparam logic [4:0] PMCS_REG_IRQ_ENABLE      = 5'h12;
	localparam logic [4:0] PMCS_REG_IRQ_STATUS      = 5'h13;
	localparam logic [4:0] PMCS_REG_EXT_SPEC_CTRL   = 5'h14;
	localparam logic [4:0] PMCS_REG_RX_ERROR_COUNT  = 5'h15;
	localparam logic [4:0] PMCS_REG_PAGE_SELECT     = 5'h16;
	localparam logic [4:0] PMCS_REG_GLOBAL_STATUS   = 5'h17;
	localparam logic [4:0] PMCS_REG_INDICATOR_CTRL  = 5'h18;
	localparam logic [4:0] PMCS_REG_INDICATOR_OVR   = 5'h19;
	localparam logic [4:0] PMCS_REG_EXT_SPEC_CTRL2  = 5'h1A;
	localparam logic [4:0] PMCS_REG_EXT_SPEC_MODE   = 5'h1B;

	// =====================================================================
	// Sequence data words
	localparam logic [15:0] PMCS_VAL_SGMII_MODE = 16'h9084;
	localparam logic [15:0] PMCS_VAL_SOFT_RESET = 16'h9140;
	localparam logic [15:0] PMCS_VAL_PAGE0      = 16'h0000;
	localparam logic [15:0] PMCS_VAL_PAGE1      = 16'h0001;
	localparam logic [15:0] PMCS_VAL_ADV_GIG    = 16'h0F00;
	localparam logic [15:0] PMCS_VAL_ADV_BASIC  = 16'h0DE1;
	localparam logic [15:0] PMCS_VAL_AN_OFF     = 16'h8140;

	// =====================================================================
	// Fields and reset values
	localparam int          PMCS_CTRL_RESET_BIT = 15;
	localparam int          PMCS_CTRL_AN_BIT    = 12;
	localparam int          PMCS_STATUS_LINK_BIT = 2;
	localparam logic [3:0]  PMCS_MODE_SGMII     = 4'h4;
	localparam logic [15:0] PMCS_RST_CONTROL    = 16'h1140;
	localparam logic [15:0] PMCS_RST_MODE       = 16'h908F;
	localparam logic [15:0] PMCS_RST_ADV_BASIC  = 16'h01E1;
	localparam logic [15:0] PMCS_RST_ADV_GIG    = 16'h0300;
	localparam logic [15:0] PMCS_STATUS_BASE    = 16'h7949;

	// =====================================================================
	// Sequence table layout
	localparam logic [3:0] PMCS_SEQ_SGMII_FIRST = 4'h0;
	localparam logic [3:0] PMCS_SEQ_SGMII_LAST  = 4'h5;
	localparam logic [3:0] PMCS_SEQ_AN_FIRST    = 4'h6;
	localparam logic [3:0] PMCS_SEQ_AN_LAST     = 4'h8;

	typedef enum logic [1:0] {
		PMCS_CMD_WRITE  = 2'b00,
		PMCS_CMD_READ   = 2'b01,
		PMCS_CMD_SGMII  = 2'b10,
		PMCS_CMD_AN_OFF = 2'b11
	} pmcs_cmd_t;

	typedef enum logic [2:0] {
		PMCS_OP_START = 3'b000,
		PMCS_OP_WRITE = 3'b001,
		PMCS_OP_RDACK = 3'b010,
		PMCS_OP_RDNAK = 3'b011,
		PMCS_OP_STOP  = 3'b100,
		PMCS_OP_END   = 3'b101
	} pmcs_op_t;

endpackage
`default_nettype wire
